// ===== design/aidr_diag_records.v
// diagnostic records, lamps and value substitution of an eight-channel analog input
//
// Strobed register access was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "aidr_regs.vh"

module aidr_diag_records #(
    parameter integer NUM_CH = 8,
    parameter integer GROUP_ONLY = 0,
    parameter integer BLINK_HALF = `AIDR_BLINK_HALF_CYCLES
) (
    input wire clock_i,
    input wire nrst_i,
    // register port
    input wire [4:0] addr_i,
    input wire [7:0] wdata_i,
    input wire wr_i,
    input wire rd_i,
    output reg [7:0] rdata_o,
    // measured values, one 16-bit word per channel
    input wire [16*NUM_CH-1:0] meas_i,
    output reg [16*NUM_CH-1:0] value_o,
    // raw error conditions per channel
    input wire [NUM_CH-1:0] param_err_i,
    input wire [NUM_CH-1:0] common_err_i,
    input wire [NUM_CH-1:0] wire_break_i,
    input wire [NUM_CH-1:0] underflow_i,
    input wire [NUM_CH-1:0] overflow_i,
    // module-wide conditions
    input wire module_err_i,
    input wire external_err_i,
    input wire supply_missing_i,
    input wire wrong_param_i,
    input wire lost_irq_i,
    // lamps and host signalling
    output reg group_fault_lamp_o,
    output reg [NUM_CH-1:0] error_lamp_o,
    output reg diag_event_o,
    output wire irq_o
);

// ==========================================================
// reset synchroniser
// nrst_i may rise anywhere in the clock period; two flops give
// every register the same clean release edge
reg rst_meta;
reg rst_sync;

// async assert, release after two edges
always @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
        rst_meta <= 1'b0;
        rst_sync <= 1'b0;
    end else begin
        rst_meta <= 1'b1;
        rst_sync <= rst_meta;
    end
end

// every other process resets from the synchronised copy
wire rst_n = rst_sync;

// ==========================================================
// functions

// channel detail byte from the raw bits
// reserved bits 2, 3 and 5 stay zero
function [7:0] detail_byte;
    input p;
    input c;
    input w;
    input u;
    input o;
    begin
        detail_byte = 8'h00;
        detail_byte[`AIDR_DT_PARAM] = p;
        detail_byte[`AIDR_DT_COMMON] = c;
        detail_byte[`AIDR_DT_WIRE] = w;
        detail_byte[`AIDR_DT_UNDER] = u;
        detail_byte[`AIDR_DT_OVER] = o;
    end
endfunction

// channel flag is the OR of the live detail bits
// the mask keeps reserved bits out even if a caller sets them
function chan_flag;
    input [7:0] d;
    begin
        chan_flag = |(d & `AIDR_DT_MASK);
    end
endfunction

// ==========================================================
// live (unfrozen) diagnostic picture
// record and lamps both derive from this one view, so they can
// never disagree on how a raw condition is decoded
reg [NUM_CH-1:0] ch_active;
reg [8*NUM_CH-1:0] live_detail;
reg [7:0] live_map;
reg [7:0] live_fault;
reg [7:0] live_lost;
integer i;

always @* begin
    live_detail = {8*NUM_CH{1'b0}};
    live_map = 8'h00;
    for (i = 0; i < NUM_CH; i = i + 1) begin
        ch_active[i] = (GROUP_ONLY == 0) || (i < 2);
        if (ch_active[i]) begin
            live_detail[8*i +: 8] = detail_byte(param_err_i[i], common_err_i[i], wire_break_i[i],
                                                underflow_i[i], overflow_i[i]);
        end
        // map has eight bits, so only channels 0..7 count
        // channel flag OR
        if (i < 8) begin
            live_map[i] = chan_flag(live_detail[8*i +: 8]);
        end
    end
    // byte 0 gathers module-wide conditions and the OR of all flags
    // summary byte 0
    live_fault = 8'h00;
    live_fault[`AIDR_SF_MODULE_ERR] = module_err_i;
    live_fault[`AIDR_SF_EXTERNAL_ERR] = external_err_i;
    live_fault[`AIDR_SF_CHANNEL_ERR] = |live_map;
    live_fault[`AIDR_SF_SUPPLY_MISSING] = supply_missing_i;
    live_fault[`AIDR_SF_WRONG_PARAM] = wrong_param_i;
    live_lost = 8'h00;
    live_lost[`AIDR_LOST_IRQ_BIT] = lost_irq_i;
end

// ==========================================================
// control and interrupt registers
reg [7:0] ctrl;
reg [7:0] irq_status;
reg [7:0] irq_mask;
reg frozen;

// control bits clear on reset, so nothing is reported before set-up
wire group_diag_en = ctrl[`AIDR_CTRL_GROUP_DIAG];
wire wire_diag_en = ctrl[`AIDR_CTRL_WIRE_DIAG];
wire irq_release = ctrl[`AIDR_CTRL_IRQ_RELEASE];

// ==========================================================
// change detection: appearing and clearing errors
// prev copies hold last cycle's live picture; a difference either way
// is an incoming or outgoing error and starts a diagnosis
reg [7:0] prev_fault;
reg [7:0] prev_map;
reg [8*NUM_CH-1:0] prev_detail;
reg prev_lost;

wire any_change = (live_fault != prev_fault) || (live_map != prev_map) ||
                  (live_detail != prev_detail);
// only the rising edge of a lost process interrupt is flagged
wire lost_rise = lost_irq_i && !prev_lost;

always @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
        prev_fault <= 8'h00;
        prev_map <= 8'h00;
        prev_detail <= {8*NUM_CH{1'b0}};
        prev_lost <= 1'b0;
    end else begin
        prev_fault <= live_fault;
        prev_map <= live_map;
        prev_detail <= live_detail;
        prev_lost <= lost_irq_i;
    end
end

// ==========================================================
// frozen record image
// follows the live picture until an event is reported, then holds
// so that a multi-byte read by the host stays consistent
reg [7:0] rec_fault;
reg [7:0] rec_lost;
reg [7:0] rec_map;
reg [8*NUM_CH-1:0] rec_detail;

wire diag_start = any_change;
wire send_event = diag_start && irq_release && !frozen;
wire release_wr = wr_i && (addr_i == `AIDR_RELEASE);

// record capture and host release
always @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
        rec_fault <= 8'h00;
        rec_lost <= 8'h00;
        rec_map <= 8'h00;
        rec_detail <= {8*NUM_CH{1'b0}};
        frozen <= 1'b0;
        diag_event_o <= 1'b0;
    end else begin
        // one-cycle pulse marks the summary record being sent
        // summary sent on error event
        diag_event_o <= send_event;
        // a report freezes even if a release write lands in the same cycle;
        // otherwise the record just sent would move under the host
        if (send_event) begin
            frozen <= 1'b1;
        end else if (release_wr) begin
            frozen <= 1'b0;
        end
        // changes while frozen are dropped, not queued; the record takes them
        // up after the release, but an event needs a further change
        // hold contents while frozen
        if (!frozen) begin
            rec_fault <= live_fault;
            rec_lost <= live_lost;
            rec_map <= live_map;
            rec_detail <= live_detail;
        end
    end
end

// ==========================================================
// control, mask and sticky status
// the mask gates only the interrupt line; status bits set regardless
always @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
        ctrl <= 8'h00;
        irq_mask <= 8'h00;
        irq_status <= 8'h00;
    end else begin
        if (wr_i && addr_i == `AIDR_CTRL) begin
            ctrl <= wdata_i;
        end
        if (wr_i && addr_i == `AIDR_IRQ_MASK) begin
            irq_mask <= wdata_i;
        end
        // read clears; a same-cycle event still sets
        if (rd_i && addr_i == `AIDR_IRQ_STATUS) begin
            irq_status <= 8'h00;
        end
        if (send_event) begin
            irq_status[`AIDR_IRQ_DIAG] <= 1'b1;
        end
        if (lost_rise) begin
            irq_status[`AIDR_IRQ_LOST] <= 1'b1;
        end
    end
end

// level output, high while any unmasked status bit is set
assign irq_o = |(irq_status & irq_mask);

// ==========================================================
// register read, data one cycle after the strobe
// unmapped addresses and detail bytes of unused channels read as zero
reg [7:0] next_rdata;

always @* begin
    next_rdata = 8'h00;
    case (addr_i)
        `AIDR_SUMMARY_FAULT_FLAGS: next_rdata = rec_fault;
        `AIDR_SUMMARY_CLASS_INFO: next_rdata = `AIDR_CLASS_INFO_RESET;
        `AIDR_SUMMARY_RESERVED: next_rdata = 8'h00;
        `AIDR_SUMMARY_LOST_IRQ: next_rdata = rec_lost;
        `AIDR_EXT_CHANNEL_TYPE: next_rdata = `AIDR_CHTYPE_ANALOG_IN;
        `AIDR_EXT_BITS_PER_CHANNEL: next_rdata = `AIDR_BITS_PER_CHANNEL;
        `AIDR_EXT_CHANNEL_COUNT: next_rdata = `AIDR_CHANNEL_COUNT;
        `AIDR_EXT_CHANNEL_ERROR_MAP: next_rdata = rec_map;
        // block-own registers above the record
        `AIDR_CTRL: next_rdata = ctrl;
        `AIDR_IRQ_STATUS: next_rdata = irq_status;
        `AIDR_IRQ_MASK: next_rdata = irq_mask;
        `AIDR_RELEASE: next_rdata = {7'h00, frozen};
        default: begin
            // twelve module bytes, details at 8..15
            if (addr_i >= `AIDR_EXT_CHANNEL0_DETAIL && addr_i <= `AIDR_EXT_CHANNEL7_DETAIL &&
                addr_i[2:0] < NUM_CH) begin
                next_rdata = rec_detail[8*addr_i[2:0] +: 8];
            end
        end
    endcase
end

// registered so the answer comes exactly one cycle after the strobe,
// and zero otherwise so a stale byte never looks like an answer
always @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
        rdata_o <= 8'h00;
    end else if (rd_i) begin
        rdata_o <= next_rdata;
    end else begin
        rdata_o <= 8'h00;
    end
end

// ==========================================================
// measured value substitution
// one cycle of latency for substituted and passed values alike;
// the codes ignore every control bit
integer k;

always @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
        value_o <= {16*NUM_CH{1'b0}};
    end else begin
        for (k = 0; k < NUM_CH; k = k + 1) begin
            // overflow is tested first and wins when both flags are high
            // fixed codes regardless of config
            if (overflow_i[k]) begin
                value_o[16*k +: 16] <= `AIDR_VALUE_OVERFLOW;
            end else if (underflow_i[k]) begin
                value_o[16*k +: 16] <= `AIDR_VALUE_UNDERFLOW;
            end else begin
                value_o[16*k +: 16] <= meas_i[16*k +: 16];
            end
        end
    end
end

// ==========================================================
// lamp blink divider; slow so the eye sees it
// one shared divider keeps all lamps in phase; the half period is a
// parameter so that simulation can use a short one
// compare with >= so a count past the end still wraps
reg [31:0] blink_cnt;
reg blink;

always @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
        blink_cnt <= 32'h0000_0000;
        blink <= 1'b0;
    end else if (blink_cnt >= BLINK_HALF - 1) begin
        blink_cnt <= 32'h0000_0000;
        blink <= ~blink;
    end else begin
        blink_cnt <= blink_cnt + 32'h0000_0001;
    end
end

// lamps follow the live errors, not the frozen record
// so they go dark as soon as an error clears, even while the
// record is still held for the host
integer j;

always @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
        group_fault_lamp_o <= 1'b0;
        error_lamp_o <= {NUM_CH{1'b0}};
    end else begin
        group_fault_lamp_o <= group_diag_en && (live_fault != 8'h00) && blink;
        for (j = 0; j < NUM_CH; j = j + 1) begin
            if (j < 8) begin
                // wire break is kept out of the general flag, lit only with its enable
                // channel lamp blinks; wire break only with its enable
                error_lamp_o[j] <= group_diag_en && blink &&
                    (chan_flag(live_detail[8*j +: 8] & ~(8'h01 << `AIDR_DT_WIRE)) ||
                     (wire_diag_en && live_detail[8*j + `AIDR_DT_WIRE]));
            end else begin
                // channels beyond eight have no map bit and stay dark
                error_lamp_o[j] <= 1'b0;
            end
        end
    end
end

endmodule
`default_nettype wire

// ===== include/aidr_regs.vh
// register offsets, field positions, reset values and constants for the diagnostic record block
// Function
// - on a channel error, report 7fffh for overflow and 8000h for underflow
// - with group diagnosis on, error blinks group fault lamp and the channel lamp
// - with wire-break diagnosis also on, wire break lights the channel error lamp
// - with diagnostic interrupt release on, send summary record when an error occurs
// - summary record is a fixed four-byte structure
// - sixteen-byte extended record repeats summary then twelve module-specific bytes
// - summary byte 0: module, external, channel, supply, parameter error bits; reset 00h
// - summary byte 1: class 0101b, bit 4 channel info present; reset 15h
// - summary byte 3 bit 6 is process interrupt lost; byte 2 reserved; zero reset
// - extended byte 4 is channel type, analog input 71h by default
// - extended byte 5 reports eight diagnostic bits per channel
// - extended byte 6 reports number of similar channels, default 04h
// - extended byte 7 holds one channel-error flag per channel
// - bytes 8 to 15 per channel: parameter, common mode, wire break, under, overflow
// - two-input variant reports diagnostics only for channels 0 and 1
// - record contents stay frozen until the host finishes diagnostic handling
// - diagnosis starts both when an error appears and when it clears
// - diagnostic interrupt goes out only when enabled by configuration
`ifndef AIDR_REGS_VH
`define AIDR_REGS_VH

// ==========================================================
// record byte offsets
`define AIDR_SUMMARY_FAULT_FLAGS 5'h00
`define AIDR_SUMMARY_CLASS_INFO 5'h01
`define AIDR_SUMMARY_RESERVED 5'h02
`define AIDR_SUMMARY_LOST_IRQ 5'h03
`define AIDR_EXT_CHANNEL_TYPE 5'h04
`define AIDR_EXT_BITS_PER_CHANNEL 5'h05
`define AIDR_EXT_CHANNEL_COUNT 5'h06
`define AIDR_EXT_CHANNEL_ERROR_MAP 5'h07
`define AIDR_EXT_CHANNEL0_DETAIL 5'h08
`define AIDR_EXT_CHANNEL7_DETAIL 5'h0f
// block-own registers
`define AIDR_CTRL 5'h10
`define AIDR_IRQ_STATUS 5'h11
`define AIDR_IRQ_MASK 5'h12
`define AIDR_RELEASE 5'h13

// ==========================================================
// summary byte 0 fields
`define AIDR_SF_MODULE_ERR 0
`define AIDR_SF_EXTERNAL_ERR 2
`define AIDR_SF_CHANNEL_ERR 3
`define AIDR_SF_SUPPLY_MISSING 4
`define AIDR_SF_WRONG_PARAM 7
// summary byte 1
`define AIDR_CLASS_ANALOG 4'h5
`define AIDR_CLASS_CHINFO 4
`define AIDR_CLASS_INFO_RESET 8'h15
// summary byte 3
`define AIDR_LOST_IRQ_BIT 6
// extended fixed bytes
`define AIDR_CHTYPE_ANALOG_IN 8'h71
`define AIDR_BITS_PER_CHANNEL 8'h08
`define AIDR_CHANNEL_COUNT 8'h04
// per-channel detail fields
`define AIDR_DT_PARAM 0
`define AIDR_DT_COMMON 1
`define AIDR_DT_WIRE 4
`define AIDR_DT_UNDER 6
`define AIDR_DT_OVER 7
`define AIDR_DT_MASK 8'hd3
// substituted measured values
`define AIDR_VALUE_OVERFLOW 16'h7fff
`define AIDR_VALUE_UNDERFLOW 16'h8000

// ==========================================================
// control register bits
`define AIDR_CTRL_GROUP_DIAG 0
`define AIDR_CTRL_WIRE_DIAG 1
`define AIDR_CTRL_IRQ_RELEASE 2
// interrupt status bits
`define AIDR_IRQ_DIAG 0
`define AIDR_IRQ_LOST 1
// lamp blink: period in ns and half period in cycles at 125 MHz
`define AIDR_BLINK_PERIOD_NS 500000000
`define AIDR_CLK_PERIOD_NS 8
`define AIDR_BLINK_HALF_CYCLES (`AIDR_BLINK_PERIOD_NS / `AIDR_CLK_PERIOD_NS / 2)

`endif

// ===== sim/aidr_diag_records_assertions.sv
// checker for the diagnostic record block ports
`timescale 1ns/1ps
`default_nettype none
module aidr_diag_records_chk #(
    parameter integer NUM_CH = 8
) (
    input wire logic clock_i,
    input wire logic nrst_i,
    input wire logic [4:0] addr_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [7:0] rdata_o,
    input wire logic [16*NUM_CH-1:0] meas_i,
    input wire logic [16*NUM_CH-1:0] value_o,
    input wire logic [NUM_CH-1:0] param_err_i,
    input wire logic [NUM_CH-1:0] common_err_i,
    input wire logic [NUM_CH-1:0] wire_break_i,
    input wire logic [NUM_CH-1:0] underflow_i,
    input wire logic [NUM_CH-1:0] overflow_i,
    input wire logic module_err_i,
    input wire logic external_err_i,
    input wire logic supply_missing_i,
    input wire logic wrong_param_i,
    input wire logic group_fault_lamp_o,
    input wire logic [NUM_CH-1:0] error_lamp_o,
    input wire logic diag_event_o
);
    // ======================================
    // helpers
    logic [1:0] warm;
    logic frz;
    logic any_err;
    logic e0;
    logic [5*NUM_CH+3:0] errs;
    assign errs = {param_err_i, common_err_i, wire_break_i, underflow_i, overflow_i,
                   module_err_i, external_err_i, supply_missing_i, wrong_param_i};
    assign any_err = |errs;
    assign e0 = param_err_i[0] | common_err_i[0] | wire_break_i[0] | underflow_i[0] | overflow_i[0];
    // warm-up covers the two-flop reset release; frz mirrors the record freeze
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            warm <= 2'h0;
            frz <= 1'b0;
        end else begin
            if (warm != 2'h3) warm <= warm + 2'h1;
            if (wr_i && addr_i == 5'h13) frz <= 1'b0;
            else if (diag_event_o) frz <= 1'b1;
        end
    end
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (warm != 2'h3);
    sequence s_quiet;
        (errs == '0) [*3];
    endsequence
    sequence s_ch0_clean;
        !(overflow_i[0] || underflow_i[0]);
    endsequence
    // ======================================
    // properties
    AST_OVF_CODE: assert property (overflow_i[0] |=> value_o[15:0] == 16'h7fff)
        else $error("overflow code missing");
    AST_UNF_CODE: assert property (underflow_i[0] && !overflow_i[0] |=> value_o[15:0] == 16'h8000)
        else $error("underflow code missing");
    AST_PASS_VALUE: assert property (s_ch0_clean |=> value_o[15:0] == $past(meas_i[15:0]))
        else $error("measured value not passed");
    AST_RDATA_IDLE: assert property (!rd_i |=> rdata_o == 8'h00)
        else $error("read data outside read slot");
    AST_EVT_PULSE: assert property (diag_event_o |=> !diag_event_o)
        else $error("event pulse too long");
    AST_EVT_FROZEN: assert property (diag_event_o |-> !frz)
        else $error("event reported while frozen");
    AST_EVT_CAUSE: assert property (diag_event_o |-> $past(errs) != $past(errs, 2))
        else $error("event without a change");
    AST_LAMP_QUIET: assert property (s_quiet |=> !group_fault_lamp_o && error_lamp_o == '0)
        else $error("lamp lit without error");
    AST_LAMP_CAUSE: assert property ($rose(error_lamp_o[0]) |-> $past(e0) || $past(e0, 2))
        else $error("channel lamp without cause");
    AST_GROUP_CAUSE: assert property ($rose(group_fault_lamp_o) |-> $past(any_err) || $past(any_err, 2))
        else $error("group lamp without cause");
endmodule
bind aidr_diag_records aidr_diag_records_chk #(.NUM_CH(NUM_CH)) u_chk (
    .clock_i(clock_i), .nrst_i(nrst_i), .addr_i(addr_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .meas_i(meas_i), .value_o(value_o), .param_err_i(param_err_i),
    .common_err_i(common_err_i), .wire_break_i(wire_break_i), .underflow_i(underflow_i),
    .overflow_i(overflow_i), .module_err_i(module_err_i), .external_err_i(external_err_i),
    .supply_missing_i(supply_missing_i), .wrong_param_i(wrong_param_i),
    .group_fault_lamp_o(group_fault_lamp_o), .error_lamp_o(error_lamp_o), .diag_event_o(diag_event_o));
`default_nettype wire

// ===== sim/aidr_diag_records_tb_top.sv
// self-checking bench for the diagnostic record block
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin fail_count++; $display("CHECK FAILED %s exp %h seen %h", n, e, a); end end
module aidr_diag_records_tb_top;
    logic clock_i, nrst_i, lost_irq;
    logic [127:0] meas;
    logic [7:0] param_err, common_err, wire_brk, under, over;
    logic [3:0] mods;
    wire [127:0] value;
    wire [7:0] rdata, wdata, err_lamp, rdata_pair;
    wire [4:0] addr;
    wire wr, rd, grp_lamp, evt, irq;
    int fail_count = 0, checked = 0, evt_n = 0;
    logic [1:0] s;
    // address in the upper byte, default value in the lower
    logic [15:0] rows [14] = '{16'h0000, 16'h0115, 16'h0200, 16'h0300, 16'h0471, 16'h0508, 16'h0604,
                               16'h0700, 16'h0800, 16'h0f00, 16'h1000, 16'h1100, 16'h1200, 16'h1400};
    aidr_diag_records #(.NUM_CH(8), .GROUP_ONLY(0), .BLINK_HALF(4)) dut (
        .clock_i(clock_i), .nrst_i(nrst_i), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
        .rdata_o(rdata), .meas_i(meas), .value_o(value), .param_err_i(param_err),
        .common_err_i(common_err), .wire_break_i(wire_brk), .underflow_i(under), .overflow_i(over),
        .module_err_i(mods[0]), .external_err_i(mods[1]), .supply_missing_i(mods[2]),
        .wrong_param_i(mods[3]), .lost_irq_i(lost_irq), .group_fault_lamp_o(grp_lamp),
        .error_lamp_o(err_lamp), .diag_event_o(evt), .irq_o(irq));
    aidr_host_model host (.clock_i(clock_i), .rdata_i(rdata), .addr_o(addr), .wdata_o(wdata),
        .wr_o(wr), .rd_o(rd));
    // two-input variant on the same bus; only its read data are checked
    aidr_diag_records #(.NUM_CH(8), .GROUP_ONLY(1), .BLINK_HALF(4)) dut_pair (
        .clock_i(clock_i), .nrst_i(nrst_i), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
        .rdata_o(rdata_pair), .meas_i(meas), .value_o(), .param_err_i(param_err),
        .common_err_i(common_err), .wire_break_i(wire_brk), .underflow_i(under), .overflow_i(over),
        .module_err_i(mods[0]), .external_err_i(mods[1]), .supply_missing_i(mods[2]),
        .wrong_param_i(mods[3]), .lost_irq_i(lost_irq), .group_fault_lamp_o(),
        .error_lamp_o(), .diag_event_o(), .irq_o());
    // ======================================
    // clock, event count and watchdog
    initial begin
        clock_i = 1'b0;
        forever #4 clock_i = ~clock_i;
    end
    always @(posedge clock_i) begin
        if (evt === 1'b1) evt_n <= evt_n + 1;
    end
    // the whole run needs well under 2000 cycles
    initial begin
        #100000;
        fail_count++;
        close_out;
    end
    // ======================================
    // helpers
    task automatic close_out;
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic rd_chk(input logic [4:0] a, input logic [7:0] e, input string n);
        logic [7:0] v;
        host.rd_reg(a, v);
        `CHK(n, e, v)
    endtask
    // bounded wait for the next reported event
    task automatic wait_evt(input int base);
        int k;
        k = 0;
        while (evt_n == base && k < 12) begin
            @(posedge clock_i);
            #1;
            k++;
        end
        `CHK("event", 1'b1, evt_n > base)
    endtask
    // collects {seen lit, seen dark} over several blink half periods; 8 is the group lamp
    task automatic watch(input int b, output logic [1:0] r);
        r = 2'b00;
        repeat (24) begin
            @(posedge clock_i);
            #1;
            if (b < 8) r = r | {err_lamp[b], ~err_lamp[b]};
            else r = r | {grp_lamp, ~grp_lamp};
        end
    endtask
    // ======================================
    // tests
    initial begin
        nrst_i = 1'b0;
        meas = {8{16'h0123}};
        {param_err, common_err, wire_brk, under, over} = '0;
        mods = 4'h0;
        lost_irq = 1'b0;
        repeat (2) @(posedge clock_i);
        nrst_i <= 1'b1;
        repeat (3) @(posedge clock_i);
        foreach (rows[i]) rd_chk(rows[i][12:8], rows[i][7:0], "default");
        host.wr_reg(5'h01, 8'hff);
        rd_chk(5'h01, 8'h15, "class after write");
        $display("test defaults done");
        host.wr_reg(5'h10, 8'h07);
        host.wr_reg(5'h12, 8'h01);
        @(posedge clock_i);
        over[2] <= 1'b1;
        wait_evt(0);
        `CHK("irq", 1'b1, irq)
        rd_chk(5'h0a, 8'h80, "ch2 detail");
        `CHK("pair ch2", 8'h00, rdata_pair)
        rd_chk(5'h07, 8'h04, "map");
        rd_chk(5'h00, 8'h08, "flags");
        `CHK("ch2 value", 16'h7fff, value[47:32])
        @(posedge clock_i);
        under[5] <= 1'b1;
        repeat (4) @(posedge clock_i);
        rd_chk(5'h07, 8'h04, "frozen map");
        `CHK("no event", 1, evt_n)
        rd_chk(5'h11, 8'h01, "status");
        rd_chk(5'h11, 8'h00, "status cleared");
        `CHK("irq low", 1'b0, irq)
        host.wr_reg(5'h13, 8'h00);
        @(posedge clock_i);
        over[2] <= 1'b0;
        wait_evt(1);
        rd_chk(5'h07, 8'h20, "map after clear");
        rd_chk(5'h0a, 8'h00, "ch2 cleared");
        rd_chk(5'h0d, 8'h40, "ch5 detail");
        `CHK("ch5 value", 16'h8000, value[95:80])
        `CHK("ch2 value", 16'h0123, value[47:32])
        host.wr_reg(5'h13, 8'h00);
        $display("test event done");
        host.wr_reg(5'h10, 8'h03);
        @(posedge clock_i);
        param_err[1] <= 1'b1;
        repeat (6) @(posedge clock_i);
        `CHK("gated event", 2, evt_n)
        rd_chk(5'h09, 8'h01, "ch1 detail");
        `CHK("pair ch1", 8'h01, rdata_pair)
        @(posedge clock_i);
        lost_irq <= 1'b1;
        repeat (2) @(posedge clock_i);
        rd_chk(5'h03, 8'h40, "lost irq byte");
        rd_chk(5'h11, 8'h03, "lost status");
        $display("test gating done");
        watch(1, s);
        `CHK("ch1 lamp", 2'b11, s)
        watch(8, s);
        `CHK("group lamp", 2'b11, s)
        host.wr_reg(5'h10, 8'h01);
        @(posedge clock_i);
        wire_brk[3] <= 1'b1;
        watch(3, s);
        `CHK("ch3 lamp off", 2'b01, s)
        host.wr_reg(5'h10, 8'h03);
        watch(3, s);
        `CHK("ch3 lamp", 2'b11, s)
        @(posedge clock_i);
        under[0] <= 1'b1;
        watch(0, s);
        `CHK("ch0 lamp", 2'b11, s)
        @(posedge clock_i);
        over[0] <= 1'b1;
        repeat (2) @(posedge clock_i);
        #1;
        `CHK("ch0 value", 16'h7fff, value[15:0])
        $display("test lamps done");
        @(posedge clock_i);
        nrst_i <= 1'b0;
        @(posedge clock_i);
        #1;
        `CHK("value in reset", 128'h0, value)
        @(posedge clock_i);
        nrst_i <= 1'b1;
        repeat (3) @(posedge clock_i);
        rd_chk(5'h10, 8'h00, "ctrl after reset");
        watch(8, s);
        `CHK("group lamp off", 2'b01, s)
        $display("test reset done");
        close_out;
    end
endmodule
`default_nettype wire

// ===== sim/aidr_host_model.sv
// host bus master model reading and releasing the diagnostic records
`timescale 1ns/1ps
`default_nettype none
module aidr_host_model (
    input wire logic clock_i,
    input wire logic [7:0] rdata_i,
    output logic [4:0] addr_o,
    output logic [7:0] wdata_o,
    output logic wr_o,
    output logic rd_o
);
    // ======================================
    // bus idle at time zero
    initial begin
        addr_o = 5'h00;
        wdata_o = 8'h00;
        wr_o = 1'b0;
        rd_o = 1'b0;
    end
    // one-cycle write; leading edge wait keeps strobes one edge apart
    task automatic wr_reg(input logic [4:0] a, input logic [7:0] d);
        @(posedge clock_i);
        addr_o <= a;
        wdata_o <= d;
        wr_o <= 1'b1;
        @(posedge clock_i);
        wr_o <= 1'b0;
    endtask
    // read data stands only in the cycle after the strobe
    task automatic rd_reg(input logic [4:0] a, output logic [7:0] d);
        @(posedge clock_i);
        addr_o <= a;
        rd_o <= 1'b1;
        @(posedge clock_i);
        rd_o <= 1'b0;
        #1;
        d = rdata_i;
    endtask
endmodule
`default_nettype wire
